// ---- shared/uart_cfg_pkg.sv ----
// Functional notes
// - tx and rx masks come from 32-entry table; rx picks even/odd-divisor column
// - data-bits codes 0111, 1000, 1001 give 7, 8, 9 bits; others reserved
// - with 9 data bits the parity field is ignored, no parity bit
// - parity 000 none, 001 odd, 010 even, 011 mark, 100 space
// - stop select gives one or two stop bits, sent and checked
// - mode 0: no flow control and no address matching
// - mode 1: hardware handshake on rts/cts or dtr/dsr pair by control bit 2
// - mode 2: software flow control using resume and suspend characters
// - mode 3: receive only after address match, transmit independent
// - mode 4: neither receive nor transmit before an address match
// - half-duplex set: receive line ignored while transmitting
// - software flow: resume character received restarts transmission
// - software flow: suspend character received halts transmission
// - multidrop modes use resume and suspend characters as addresses
// - baud uses 19-bit divisor plus 16-bit tx and rx mask patterns
package uart_cfg_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DIV_OFS = 8'h04;
  localparam logic [7:0] IDX_OFS = 8'h08;
  localparam logic [7:0] FMT_OFS = 8'h0c;
  localparam logic [7:0] FC_OFS = 8'h10;
  localparam logic [7:0] RES_OFS = 8'h14;
  localparam logic [7:0] SUS_OFS = 8'h18;
  localparam logic [7:0] TXD_OFS = 8'h1c;
  localparam logic [7:0] STAT_OFS = 8'h20;

  // control bits and status field positions
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_DTR_SEL = 2;
  localparam int FC_HDX = 3;
  localparam int FMT_STOP2 = 7;
  localparam int ST_RX_VLD = 9;
  localparam int ST_TX_BUSY = 10;
  localparam int ST_SUSP = 11;
  localparam int ST_MATCH = 12;
  localparam int ST_PERR = 13;
  localparam int ST_FERR = 14;

  // reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [18:0] DIV_RST = 19'h00000;
  localparam logic [4:0] IDX_RST = 5'h00;
  localparam logic [7:0] FMT_RST = 8'h00;
  localparam logic [3:0] FC_RST = 4'h0;
  localparam logic [7:0] CHAR_RST = 8'h00;

  // data-bit codes and parity codes
  localparam logic [3:0] DB_7 = 4'h7;
  localparam logic [3:0] DB_8 = 4'h8;
  localparam logic [3:0] DB_9 = 4'h9;
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_EVEN = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [2:0] PAR_SPACE = 3'h4;
  localparam logic [19:0] MIN_BIT = 20'h00002;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // fractional mask tables, index 0 first
  localparam logic [15:0] TX_MASK_TAB [32] = '{
    16'h0000, 16'h0000, 16'h0100, 16'h0020, 16'h0010, 16'h0208, 16'h0104, 16'h0844,
    16'h0444, 16'h0122, 16'h0912, 16'h0492, 16'h0252, 16'h094a, 16'h052a, 16'h0aaa,
    16'h0aaa, 16'h0555, 16'h0b55, 16'h06b5, 16'h05b5, 16'h0b6d, 16'h076d, 16'h0edd,
    16'h0ddd, 16'h07bb, 16'h0f7b, 16'h0df7, 16'h07f7, 16'h0fdf, 16'h0f7f, 16'h0fff};
  localparam logic [15:0] RX_EVEN_TAB [32] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0400, 16'h0100, 16'h0040, 16'h0820, 16'h0210,
    16'h0110, 16'h0888, 16'h0448, 16'h0248, 16'h0928, 16'h04a4, 16'h0aa4, 16'h0954,
    16'h0554, 16'h0ad4, 16'h0ab4, 16'h05ac, 16'h0d6c, 16'h0b6a, 16'h06da, 16'h0dda,
    16'h0bba, 16'h0f7a, 16'h0ef6, 16'h0bf6, 16'h0fee, 16'h0fbe, 16'h0efe, 16'h0ffe};
  localparam logic [15:0] RX_ODD_TAB [32] = '{
    16'h0000, 16'h0000, 16'h0100, 16'h0020, 16'h0010, 16'h0208, 16'h0108, 16'h0884,
    16'h0444, 16'h0224, 16'h0924, 16'h0492, 16'h0292, 16'h0a52, 16'h054a, 16'h04aa,
    16'h0aaa, 16'h05aa, 16'h055a, 16'h0b56, 16'h06d6, 16'h0db6, 16'h0bb6, 16'h076e,
    16'h0eee, 16'h0dde, 16'h07de, 16'h0f7e, 16'h0efe, 16'h07fe, 16'h0ffe, 16'h0ffd};

  typedef enum logic [2:0] {
    FC_NONE = 3'b000,
    FC_HW = 3'b001,
    FC_SW = 3'b010,
    FC_DROP_RX = 3'b011,
    FC_DROP_ALL = 3'b100
  } flow_mode_t;

  typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} tx_state_t;
  typedef enum logic {RX_IDLE = 1'b0, RX_BITS = 1'b1} rx_state_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  // reserved data codes fall back to 8 bits
  function automatic logic [3:0] data_len(logic [7:0] fmt);
    if (fmt[3:0] == DB_7 || fmt[3:0] == DB_9) begin
      return fmt[3:0];
    end
    return DB_8;
  endfunction

  function automatic logic par_en(logic [7:0] fmt);
    return data_len(fmt) != DB_9 && fmt[6:4] != 3'h0 && fmt[6:4] <= PAR_SPACE;
  endfunction

  // start + data + parity + stop(s)
  function automatic logic [3:0] frame_len(logic [7:0] fmt);
    return 4'h2 + data_len(fmt) + {3'h0, par_en(fmt)} + {3'h0, fmt[FMT_STOP2]};
  endfunction

  function automatic logic [8:0] keep_bits(logic [8:0] d, logic [3:0] n);
    return d & ~(9'h1ff << n);
  endfunction

  function automatic logic par_bit(logic [2:0] code, logic [8:0] d);
    case (code)
      PAR_ODD: return ~^d;
      PAR_EVEN: return ^d;
      PAR_MARK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // one stretched bit length in clocks
  function automatic logic [19:0] bit_len(logic [18:0] div, logic m);
    logic [19:0] b;
    b = (div < 19'h00002) ? MIN_BIT : {1'b0, div};
    return b + {19'h0, m};
  endfunction

endpackage

// ---- core/uart_format_flow_control.sv ----
`timescale 1ns/1ns
module uart_format_flow_control (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // register bus
  input wire uart_cfg_pkg::axil_req_t i_axi,
  output uart_cfg_pkg::axil_rsp_t o_axi,
  // serial line
  input wire logic i_rx,
  output logic o_tx,
  // handshake pins
  input wire logic i_cts_n,
  input wire logic i_dsr_n,
  output logic o_rts_n,
  output logic o_dtr_n
);

  logic [2:0] ctrl_r;
  logic [18:0] div_r;
  logic [4:0] idx_r;
  logic [7:0] fmt_r;
  logic [3:0] fc_r;
  logic [7:0] res_r;
  logic [7:0] sus_r;
  logic [8:0] txd_r;
  logic tx_req_r;
  logic [8:0] rxd_r;
  logic rx_vld_r;
  logic perr_r;
  logic ferr_r;
  logic match_r;
  logic susp_r;
  logic tx_r;
  logic rts_n_r;
  logic dtr_n_r;

  // bus state
  logic aw_have_r, w_have_r, awready_r, wready_r, bvalid_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r;
  logic arready_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic aw_have_nxt, w_have_nxt, do_wr, rd_hs, rd_stat;
  logic [31:0] wr_val, rd_mux;
  logic rd_ok;

  // line state
  uart_cfg_pkg::tx_state_t tx_st_r;
  uart_cfg_pkg::rx_state_t rx_st_r;
  logic [12:0] frame_r, rx_sh_r;
  logic [3:0] tx_idx_r, rx_idx_r;
  logic [19:0] tx_cnt_r, rx_cnt_r;
  logic rx_done_r;

  // decoded configuration
  uart_cfg_pkg::flow_mode_t mode;
  logic [3:0] nbits, flen;
  logic pe, two, hdx, tx_busy, cts_ok, tx_start;
  logic [15:0] tx_mask, rx_mask;
  logic [8:0] rx_dat;
  logic rx_pb, rx_stop1, rx_stop2, rx_ferr, rx_perr;
  logic is_res, is_sus, is_addr;

  assign nbits = uart_cfg_pkg::data_len(fmt_r);
  assign pe = uart_cfg_pkg::par_en(fmt_r);
  assign two = fmt_r[uart_cfg_pkg::FMT_STOP2];
  assign flen = uart_cfg_pkg::frame_len(fmt_r);
  assign hdx = fc_r[uart_cfg_pkg::FC_HDX];
  assign tx_busy = tx_st_r == uart_cfg_pkg::TX_SHIFT;

  // reserved mode codes behave as mode 0
  always_comb begin
    unique case (fc_r[2:0])
      3'b001: mode = uart_cfg_pkg::FC_HW;
      3'b010: mode = uart_cfg_pkg::FC_SW;
      3'b011: mode = uart_cfg_pkg::FC_DROP_RX;
      3'b100: mode = uart_cfg_pkg::FC_DROP_ALL;
      default: mode = uart_cfg_pkg::FC_NONE;
    endcase
  end

  // mask lookup; rx column follows divisor parity
  assign tx_mask = uart_cfg_pkg::TX_MASK_TAB[idx_r];
  assign rx_mask = div_r[0] ? uart_cfg_pkg::RX_ODD_TAB[idx_r]
                            : uart_cfg_pkg::RX_EVEN_TAB[idx_r];

  // transmit gating per flow mode
  assign cts_ok = mode != uart_cfg_pkg::FC_HW ||
                  (ctrl_r[uart_cfg_pkg::CTRL_DTR_SEL] ? !i_dsr_n : !i_cts_n);
  assign tx_start = !tx_busy && tx_req_r && ctrl_r[uart_cfg_pkg::CTRL_TX_EN] && cts_ok
                    && !(mode == uart_cfg_pkg::FC_SW && susp_r)
                    && !(mode == uart_cfg_pkg::FC_DROP_ALL && !match_r);

  // write channel: address and data taken in either order
  assign do_wr = aw_have_r && w_have_r && !bvalid_r;
  assign aw_have_nxt = !do_wr && (aw_have_r || (i_axi.awvalid && awready_r));
  assign w_have_nxt = !do_wr && (w_have_r || (i_axi.wvalid && wready_r));
  always_comb begin
    wr_val = w_data_r;
    for (int b = 0; b < 4; b++) begin
      if (!w_strb_r[b]) begin
        wr_val[8*b +: 8] = rd_mux_at(aw_addr_r, b);
      end
    end
  end

  // read value of one byte lane, for partial writes
  function automatic logic [7:0] rd_mux_at(logic [7:0] a, int b);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      uart_cfg_pkg::CTRL_OFS: v = {29'h0, ctrl_r};
      uart_cfg_pkg::DIV_OFS: v = {13'h0, div_r};
      uart_cfg_pkg::IDX_OFS: v = {27'h0, idx_r};
      uart_cfg_pkg::FMT_OFS: v = {24'h0, fmt_r};
      uart_cfg_pkg::FC_OFS: v = {28'h0, fc_r};
      uart_cfg_pkg::RES_OFS: v = {24'h0, res_r};
      uart_cfg_pkg::SUS_OFS: v = {24'h0, sus_r};
      uart_cfg_pkg::TXD_OFS: v = {23'h0, txd_r};
      uart_cfg_pkg::STAT_OFS: v = {17'h0, ferr_r, perr_r, match_r, susp_r,
                                   tx_busy | tx_req_r, rx_vld_r, rxd_r};
      default: v = 32'h0;
    endcase
    return v[8*b +: 8];
  endfunction

  function automatic logic addr_ok(logic [7:0] a);
    return a <= uart_cfg_pkg::STAT_OFS && a[1:0] == 2'h0;
  endfunction

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= uart_cfg_pkg::RESP_OK;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awready_r <= !aw_have_nxt;
      wready_r <= !w_have_nxt;
      if (i_axi.awvalid && awready_r) begin
        aw_addr_r <= i_axi.awaddr;
      end
      if (i_axi.wvalid && wready_r) begin
        w_data_r <= i_axi.wdata;
        w_strb_r <= i_axi.wstrb;
      end
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r <= addr_ok(aw_addr_r) ? uart_cfg_pkg::RESP_OK : uart_cfg_pkg::RESP_SLVERR;
      end else if (i_axi.bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read channel: one cycle from address to data
  assign rd_hs = i_axi.arvalid && arready_r;
  assign rd_stat = rd_hs && i_axi.araddr == uart_cfg_pkg::STAT_OFS;
  assign rd_ok = addr_ok(i_axi.araddr);
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      rd_mux[8*b +: 8] = rd_mux_at(i_axi.araddr, b);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= uart_cfg_pkg::RESP_OK;
    end else if (rd_hs) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_ok ? uart_cfg_pkg::RESP_OK : uart_cfg_pkg::RESP_SLVERR;
    end else if (rvalid_r && i_axi.rready) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  assign o_axi = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r,
                   bresp: bresp_r, arready: arready_r, rvalid: rvalid_r,
                   rdata: rdata_r, rresp: rresp_r};

  // configuration registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r <= uart_cfg_pkg::CTRL_RST;
      div_r <= uart_cfg_pkg::DIV_RST;
      idx_r <= uart_cfg_pkg::IDX_RST;
      fmt_r <= uart_cfg_pkg::FMT_RST;
      fc_r <= uart_cfg_pkg::FC_RST;
      res_r <= uart_cfg_pkg::CHAR_RST;
      sus_r <= uart_cfg_pkg::CHAR_RST;
      txd_r <= 9'h000;
    end else if (do_wr) begin
      case (aw_addr_r)
        uart_cfg_pkg::CTRL_OFS: ctrl_r <= wr_val[2:0];
        uart_cfg_pkg::DIV_OFS: div_r <= wr_val[18:0];
        uart_cfg_pkg::IDX_OFS: idx_r <= wr_val[4:0];
        uart_cfg_pkg::FMT_OFS: fmt_r <= wr_val[7:0];
        uart_cfg_pkg::FC_OFS: begin
          // mode changes while tx or rx is enabled are dropped instead of corrupting state
          if (ctrl_r[1:0] == 2'h0) begin
            fc_r <= wr_val[3:0];
          end
        end
        uart_cfg_pkg::RES_OFS: res_r <= wr_val[7:0];
        uart_cfg_pkg::SUS_OFS: sus_r <= wr_val[7:0];
        uart_cfg_pkg::TXD_OFS: begin
          if (!tx_req_r) begin
            txd_r <= wr_val[8:0];
          end
        end
        default: ;
      endcase
    end
  end

  // transmitter; bit length stretched by the mask bit of its position
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_st_r <= uart_cfg_pkg::TX_IDLE;
      tx_req_r <= 1'b0;
      frame_r <= 13'h1fff;
      tx_idx_r <= 4'h0;
      tx_cnt_r <= 20'h0;
      tx_r <= 1'b1;
    end else begin
      if (tx_start) begin
        tx_req_r <= 1'b0;
      end
      if (do_wr && aw_addr_r == uart_cfg_pkg::TXD_OFS) begin
        tx_req_r <= 1'b1;
      end
      unique case (tx_st_r)
        uart_cfg_pkg::TX_IDLE: begin
          tx_r <= 1'b1;
          if (tx_start) begin
            tx_st_r <= uart_cfg_pkg::TX_SHIFT;
            frame_r <= build_frame(txd_r);
            tx_idx_r <= 4'h0;
            tx_cnt_r <= uart_cfg_pkg::bit_len(div_r, tx_mask[0]) - 20'h1;
            tx_r <= 1'b0;
          end
        end
        uart_cfg_pkg::TX_SHIFT: begin
          if (tx_cnt_r != 20'h0) begin
            tx_cnt_r <= tx_cnt_r - 20'h1;
          end else if (tx_idx_r == flen - 4'h1) begin
            tx_st_r <= uart_cfg_pkg::TX_IDLE;
            tx_r <= 1'b1;
          end else begin
            tx_idx_r <= tx_idx_r + 4'h1;
            tx_r <= frame_r[tx_idx_r + 4'h1];
            tx_cnt_r <= uart_cfg_pkg::bit_len(div_r, tx_mask[tx_idx_r + 4'h1])
                        - 20'h1;
          end
        end
      endcase
    end
  end

  function automatic logic [12:0] build_frame(logic [8:0] d);
    logic [12:0] f;
    f = 13'h1ffe;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(nbits)) begin
        f[i + 1] = d[i];
      end
    end
    if (pe) begin
      f[nbits + 4'h1] = uart_cfg_pkg::par_bit(fmt_r[6:4], uart_cfg_pkg::keep_bits(d, nbits));
    end
    return f;
  endfunction

  // receiver; samples mid-bit, half duplex drops the character
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_st_r <= uart_cfg_pkg::RX_IDLE;
      rx_sh_r <= 13'h0;
      rx_idx_r <= 4'h0;
      rx_cnt_r <= 20'h0;
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      if (hdx && tx_busy) begin
        rx_st_r <= uart_cfg_pkg::RX_IDLE;
      end else begin
        unique case (rx_st_r)
          uart_cfg_pkg::RX_IDLE: begin
            if (ctrl_r[uart_cfg_pkg::CTRL_RX_EN] && !i_rx) begin
              rx_st_r <= uart_cfg_pkg::RX_BITS;
              rx_idx_r <= 4'h0;
              // aim half a bit in; the detecting edge already counts as one
              rx_cnt_r <= (uart_cfg_pkg::bit_len(div_r, rx_mask[0]) >> 1) - 20'h1;
            end
          end
          uart_cfg_pkg::RX_BITS: begin
            if (rx_cnt_r != 20'h0) begin
              rx_cnt_r <= rx_cnt_r - 20'h1;
            end else if (rx_idx_r == 4'h0 && i_rx) begin
              rx_st_r <= uart_cfg_pkg::RX_IDLE; // false start
            end else begin
              rx_sh_r[rx_idx_r] <= i_rx;
              rx_idx_r <= rx_idx_r + 4'h1;
              rx_cnt_r <= uart_cfg_pkg::bit_len(div_r, rx_mask[rx_idx_r + 4'h1])
                          - 20'h1;
              if (rx_idx_r == flen - 4'h1) begin
                rx_st_r <= uart_cfg_pkg::RX_IDLE;
                rx_done_r <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // character checks
  assign rx_dat = uart_cfg_pkg::keep_bits(rx_sh_r[9:1], nbits);
  assign rx_pb = rx_sh_r[nbits + 4'h1];
  assign rx_stop1 = rx_sh_r[nbits + 4'h1 + {3'h0, pe}];
  assign rx_stop2 = rx_sh_r[nbits + 4'h2 + {3'h0, pe}];
  assign rx_ferr = !rx_stop1 || (two && !rx_stop2);
  assign rx_perr = pe && rx_pb != uart_cfg_pkg::par_bit(fmt_r[6:4], rx_dat);
  assign is_res = rx_dat[7:0] == res_r;
  assign is_sus = rx_dat[7:0] == sus_r;
  // 9-bit frames mark addresses by bit 8, else a matching byte is one
  assign is_addr = (nbits == uart_cfg_pkg::DB_9) ? rx_dat[8] : (is_res || is_sus);

  // received data, flow state and address match
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rxd_r <= 9'h000;
      rx_vld_r <= 1'b0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
      match_r <= 1'b0;
      susp_r <= 1'b0;
    end else begin
      if (rd_stat) begin
        rx_vld_r <= 1'b0;
      end
      if (ctrl_r[1:0] == 2'h0) begin
        match_r <= 1'b0;
        susp_r <= 1'b0;
      end else if (rx_done_r) begin
        perr_r <= rx_perr;
        ferr_r <= rx_ferr;
        unique case (mode)
          uart_cfg_pkg::FC_SW: begin
            if (is_res) begin
              susp_r <= 1'b0;
            end else if (is_sus) begin
              susp_r <= 1'b1;
            end else begin
              rxd_r <= rx_dat;
              rx_vld_r <= 1'b1;
            end
          end
          uart_cfg_pkg::FC_DROP_RX, uart_cfg_pkg::FC_DROP_ALL: begin
            if (is_addr) begin
              match_r <= is_res || is_sus;
            end else if (match_r) begin
              rxd_r <= rx_dat;
              rx_vld_r <= 1'b1;
            end
          end
          default: begin
            rxd_r <= rx_dat;
            rx_vld_r <= 1'b1;
          end
        endcase
      end
    end
  end

  // handshake outputs; a held character means no room
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rts_n_r <= 1'b1;
      dtr_n_r <= 1'b1;
    end else begin
      rts_n_r <= !(mode == uart_cfg_pkg::FC_HW && !ctrl_r[2] && !rx_vld_r);
      dtr_n_r <= !(mode == uart_cfg_pkg::FC_HW && ctrl_r[2] && !rx_vld_r);
    end
  end

  assign o_tx = tx_r;
  assign o_rts_n = rts_n_r;
  assign o_dtr_n = dtr_n_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_sus_seen;
    rx_done_r && mode == uart_cfg_pkg::FC_SW && is_sus && !is_res;
  endsequence
  sequence s_res_seen;
    rx_done_r && mode == uart_cfg_pkg::FC_SW && is_res;
  endsequence

  a_start_bit_low: assert property (
    tx_start |=> !o_tx ##1 !o_tx) else $error("start bit not low");
  a_nine_no_par: assert property (
    tx_start && fmt_r[3:0] == 4'h9 |-> flen == 4'hb + {3'h0, two})
    else $error("parity added to 9-bit frame");
  a_stop_two: assert property (
    tx_start && fmt_r == 8'h88 |-> flen == 4'hb) else $error("stop count wrong");
  a_sw_suspend: assert property (
    s_sus_seen |=> susp_r ##1 !tx_start) else $error("suspend not taken");
  a_sw_resume: assert property (
    s_res_seen |=> !susp_r) else $error("resume not taken");
  a_drop_tx_gate: assert property (
    mode == uart_cfg_pkg::FC_DROP_ALL && !match_r |-> !tx_start)
    else $error("tx before address match");
  a_drop_rx_gate: assert property (
    rx_done_r && mode == uart_cfg_pkg::FC_DROP_RX && !match_r |=> !$rose(rx_vld_r))
    else $error("rx before address match");
  a_hdx_rx_idle: assert property (
    hdx && tx_busy |=> rx_st_r == uart_cfg_pkg::RX_IDLE) else $error("rx during tx");
  a_hw_cts_gate: assert property (
    mode == uart_cfg_pkg::FC_HW && (ctrl_r[2] ? i_dsr_n : i_cts_n) |-> !tx_start)
    else $error("tx without handshake");
  a_mask_first: assert property (
    tx_start |=> tx_cnt_r == uart_cfg_pkg::bit_len(div_r, tx_mask[0]) - 20'h1)
    else $error("first bit length wrong");

endmodule

// ---- dv/serial_peer.sv ----
`timescale 1ns/1ns
module serial_peer (
  // clock
  input wire logic i_clk,
  // line from the device and line to it
  input wire logic i_line,
  output logic o_line
);
  // idle line rests high, as the pull-up would leave it
  initial o_line = 1'b1;

  // send a prepared frame, bit 0 first, bl clocks per bit
  task automatic put(input logic [12:0] v, input int n, input int bl);
    for (int i = 0; i < n; i++) begin
      o_line <= v[i];
      repeat (bl) @(posedge i_clk);
    end
    o_line <= 1'b1;
  endtask

  // sample n bits at mid-bit; unsampled bits stay high
  task automatic take(input int n, input int bl, output logic [12:0] v);
    v = '1;
    @(negedge i_line);
    repeat (bl / 2) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      v[i] = i_line;
      if (i < n - 1) repeat (bl) @(posedge i_clk);
    end
  endtask
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ns
module tb;
  logic i_clk, i_rstn, i_rx, i_cts_n, i_dsr_n, o_tx, o_rts_n, o_dtr_n;
  uart_cfg_pkg::axil_req_t req;
  uart_cfg_pkg::axil_rsp_t rsp;
  int num_errors, samples_checked, seed, n, k;
  logic [31:0] rv;
  logic [1:0] rr;
  logic [12:0] got, ev, rf;
  logic [8:0] d;
  logic [7:0] f;
  logic [3:0] dbs [4] = '{4'h7, 4'h8, 4'h9, 4'hc};
  logic [3:0] fcs [3] = '{4'h1, 4'h3, 4'h8};
  logic vld [3] = '{1'b1, 1'b0, 1'b0};

  uart_format_flow_control dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_axi(req), .o_axi(rsp),
    .i_rx(i_rx), .o_tx(o_tx), .i_cts_n(i_cts_n), .i_dsr_n(i_dsr_n), .o_rts_n(o_rts_n),
    .o_dtr_n(o_dtr_n));
  serial_peer peer_u (.i_clk(i_clk), .i_line(o_tx), .o_line(i_rx));

  // 100 ns clock
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  // expected frame, bit 0 = start; d is trimmed to the data width
  function automatic logic [12:0] exp_frame(input logic [7:0] fm, inout logic [8:0] dd,
                                            output int len);
    int nd;
    logic pe;
    logic [12:0] v;
    nd = (fm[3:0] == 4'h7) ? 7 : (fm[3:0] == 4'h9) ? 9 : 8;
    dd = dd & 9'((1 << nd) - 1);
    pe = nd != 9 && fm[6:4] != 3'h0 && fm[6:4] <= 3'h4;
    v = '1;
    v[0] = 1'b0;
    for (int i = 0; i < nd; i++) v[i + 1] = dd[i];
    if (pe) v[nd + 1] = fm[6:4] == 3'h1 ? ~^dd : fm[6:4] == 3'h2 ? ^dd : fm[6:4] == 3'h3;
    len = nd + 2 + int'(pe) + int'(fm[7]);
    return v;
  endfunction

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    logic aw, w;
    @(posedge i_clk);
    aw = 1'b0;
    w = 1'b0;
    req <= '{awvalid:1'b1, awaddr:a, wvalid:1'b1, wdata:dt, wstrb:4'hf, bready:1'b1, default:'0};
    while (!(aw && w)) begin
      @(posedge i_clk);
      aw = aw | rsp.awready;
      w = w | rsp.wready;
      req.awvalid <= !aw;
      req.wvalid <= !w;
    end
    while (!rsp.bvalid) @(posedge i_clk);
    rr = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    req <= '{arvalid:1'b1, araddr:a, rready:1'b1, default:'0};
    do @(posedge i_clk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge i_clk); while (!rsp.rvalid);
    rv = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // flow mode only changes with the uart disabled, upper bits zero
  task automatic setup(input logic [3:0] fc);
    wr(uart_cfg_pkg::CTRL_OFS, 32'h0);
    wr(uart_cfg_pkg::FC_OFS, {28'h0, fc});
    wr(uart_cfg_pkg::CTRL_OFS, 32'h3);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, well beyond the expected run
  initial begin
    repeat (40000) @(posedge i_clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    seed = 32'h1b7edaa3;
    num_errors = 0;
    samples_checked = 0;
    req = '0;
    i_rstn = 1'b0;
    i_cts_n = 1'b0;
    i_dsr_n = 1'b1;
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    // divisor 4 and mask index 0: no fraction, every bit 4 clocks
    wr(uart_cfg_pkg::DIV_OFS, 32'h4);
    wr(uart_cfg_pkg::RES_OFS, 32'h11);
    wr(uart_cfg_pkg::SUS_OFS, 32'h13);
    rd(uart_cfg_pkg::RES_OFS);
    chk(rv, 32'h11);
    rd(uart_cfg_pkg::SUS_OFS);
    chk(rv, 32'h13);
    rd(8'h24);
    chk({30'h0, rr}, {30'h0, uart_cfg_pkg::RESP_SLVERR});
    wr(8'h24, 32'h0);
    chk({30'h0, rr}, {30'h0, uart_cfg_pkg::RESP_SLVERR});
    setup(4'h0);
    // every data code, parity code and stop count, both directions
    for (int i = 0; i < 40; i++) begin
      f = {i[0], 3'((i / 2) % 5), dbs[i / 10]};
      wr(uart_cfg_pkg::FMT_OFS, {24'h0, f});
      d = 9'($random(seed));
      ev = exp_frame(f, d, n);
      fork
        peer_u.take(n, 4, got);
        wr(uart_cfg_pkg::TXD_OFS, {23'h0, d});
      join
      chk({19'h0, got}, {19'h0, ev});
      d = 9'($random(seed));
      ev = exp_frame(f, d, n);
      peer_u.put(ev, n, 4);
      rd(uart_cfg_pkg::STAT_OFS);
      chk({20'h0, rv[14:13], rv[9:0]}, {20'h0, 2'b0, 1'b1, d});
    end
    // hw handshake, multidrop without address, half duplex; rx alongside tx
    wr(uart_cfg_pkg::FMT_OFS, 32'h8);
    for (int m = 0; m < 3; m++) begin
      setup(fcs[m]);
      if (m == 0) begin
        chk({30'h0, o_rts_n, o_dtr_n}, 32'h1);
        // switch to the dtr/dsr pair; dsr still high holds the character back
        wr(uart_cfg_pkg::CTRL_OFS, 32'h7);
        @(posedge i_clk);
        chk({30'h0, o_rts_n, o_dtr_n}, 32'h2);
      end
      d = 9'h080 | 9'($random(seed));
      ev = exp_frame(8'h08, d, n);
      fork
        peer_u.take(n, 4, got);
        wr(uart_cfg_pkg::TXD_OFS, {23'h0, d});
        peer_u.put(ev, n, 4);
        if (m == 0) begin
          repeat (30) @(posedge i_clk);
          chk({31'h0, o_tx}, 32'h1);
          i_dsr_n <= 1'b0;
        end
      join
      chk({19'h0, got}, {19'h0, ev});
      rd(uart_cfg_pkg::STAT_OFS);
      chk({31'h0, rv[9]}, {31'h0, vld[m]});
    end
    // software flow, then multidrop transmit gating; k=0 suspend, k=1 address
    for (k = 0; k < 2; k++) begin
      setup(k == 0 ? 4'h2 : 4'h4);
      d = k == 0 ? 9'h013 : 9'h011;
      rf = exp_frame(8'h08, d, n);
      if (k == 0) peer_u.put(rf, n, 4);
      d = 9'h0a5;
      ev = exp_frame(8'h08, d, n);
      wr(uart_cfg_pkg::TXD_OFS, {23'h0, d});
      repeat (60) @(posedge i_clk);
      chk({31'h0, o_tx}, 32'h1);
      d = 9'h011;
      rf = exp_frame(8'h08, d, n);
      fork
        peer_u.take(n, 4, got);
        peer_u.put(rf, n, 4);
      join
      chk({19'h0, got}, {19'h0, ev});
      rd(uart_cfg_pkg::STAT_OFS);
      chk({31'h0, rv[12]}, {31'h0, k == 1});
    end
    // index 21: tx mask bit 0 is set, so the start bit lasts one clock more
    wr(uart_cfg_pkg::IDX_OFS, 32'h15);
    fork
      wr(uart_cfg_pkg::TXD_OFS, 32'hff);
      begin
        @(negedge o_tx);
        @(posedge i_clk);
        for (n = 0; !o_tx; n++) @(posedge i_clk);
      end
    join
    chk(n, 32'h5);
    report_and_stop();
  end
endmodule
